// [rtl/sea_pkg.sv]
package sea_pkg;
    // Register byte offsets on the bus
    localparam logic [11:0] SEA_EE_OFS       = 12'h34c;  // Serial EEPROM byte access
    localparam logic [11:0] SEA_IOE_OFS      = 12'h350;  // Expander signal access
    localparam logic [11:0] SEA_IRQ_ST_OFS   = 12'h360;  // Interrupt status, write one to clear
    localparam logic [11:0] SEA_IRQ_MASK_OFS = 12'h364;  // Interrupt enable mask

    // EEPROM access register fields
    localparam int SEA_EE_ADDR_LSB = 0;   // Byte location, 16 bits
    localparam int SEA_EE_DATA_LSB = 16;  // Data byte, write launches
    localparam int SEA_EE_BUSY_BIT = 24;  // Access underway
    localparam int SEA_EE_DONE_BIT = 25;  // Access finished, write one to clear
    localparam int SEA_EE_OP_BIT   = 26;  // Operation select

    // Expander register fields
    localparam int SEA_IOE_DATA_LSB    = 0;   // Sixteen signal bits
    localparam int SEA_IOE_REFRESH_BIT = 24;  // Refresh trigger, reads zero
    localparam int SEA_IOE_TM_BIT      = 25;  // Test mode
    localparam int SEA_IOE_SEL_LSB     = 26;  // Four-bit expander select
    localparam int SEA_IOE_DONE_BIT    = 31;  // Transaction done, write one to clear

    // Interrupt status bits
    localparam int SEA_IRQ_EE  = 0;  // EEPROM access finished
    localparam int SEA_IRQ_IOE = 1;  // Expander transaction finished
    localparam int SEA_IRQ_W   = 2;  // Number of interrupt sources

    // Operation select codes
    localparam logic SEA_OP_WRITE = 1'b0;
    localparam logic SEA_OP_READ  = 1'b1;

    // Expander count and valid select codes
    localparam int          SEA_NUM_IOE = 4;
    localparam logic [3:0]  SEA_IOE0    = 4'h0;
    localparam logic [3:0]  SEA_IOE1    = 4'h1;
    localparam logic [3:0]  SEA_IOE2    = 4'h2;
    localparam logic [3:0]  SEA_IOE4    = 4'h4;

    // Reset values
    localparam logic [15:0] SEA_RST_ADDR = 16'h0000;
    localparam logic [7:0]  SEA_RST_DATA = 8'h00;
    localparam logic [15:0] SEA_RST_PINS = 16'h0000;
    localparam logic [3:0]  SEA_RST_SEL  = 4'h0;

    // Kinds of master SMBus job
    typedef enum logic [1:0] {
        SEA_KIND_EE_WR   = 2'h0,
        SEA_KIND_EE_RD   = 2'h1,
        SEA_KIND_IOE_REF = 2'h2,
        SEA_KIND_IOE_UPD = 2'h3
    } sea_kind_t;

    // Job sequencer states, one-hot
    typedef enum logic [2:0] {
        SEA_ST_IDLE = 3'b001,
        SEA_ST_EE   = 3'b010,
        SEA_ST_IOE  = 3'b100
    } sea_state_t;
endpackage : sea_pkg

// [rtl/sea_sticky_bit.sv]
`timescale 1ns/1ns
// Sticky flag: hardware sets, software clears by writing one
module sea_sticky_bit (
    input  wire logic clk_i,    // Core clock
    input  wire logic rst_i,    // Synchronous reset
    input  wire logic set_i,    // Event pulse
    input  wire logic clr_i,    // Write-one clear
    output logic      q_o       // Flag state
);
    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else if (set_i) begin
            q_o <= 1'b1;
        end else if (clr_i) begin
            q_o <= 1'b0;
        end
    end
endmodule : sea_sticky_bit

// [rtl/sea_wb_port.sv]
`timescale 1ns/1ns
// Classic Wishbone handshake: ack one cycle after the request
module sea_wb_port (
    input  wire logic clk_i,    // Core clock
    input  wire logic rst_i,    // Synchronous reset
    input  wire logic cyc_i,    // Bus cycle
    input  wire logic stb_i,    // Strobe
    input  wire logic we_i,     // Write enable
    output logic      ack_o,    // Acknowledge, one cycle
    output logic      wr_o,     // Write commit, at the ack edge
    output logic      rd_o      // Read capture, before the ack
);
    // Ack toggles down after one cycle so it never stays high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
        end
    end

    // Write lands on the edge where the master sees ack
    assign wr_o = cyc_i & stb_i & we_i & ack_o;
    // Read data is latched as ack rises
    assign rd_o = cyc_i & stb_i & ~we_i & ~ack_o;
endmodule : sea_wb_port

// [rtl/sea_access.sv]
// How it works
// - Sixteen-bit writable EEPROM byte location field
// - Data field write launches one EEPROM access
// - Write access stores the written data byte
// - Read access returns EEPROM byte after done
// - Busy bit high while access underway
// - Done flag set at finish, write-one clears
// - Operation select: zero write, one read
// - Data bits show selected expander pin states
// - Expander data writes ignored outside test mode
// - Test mode drives outputs from written data
// - Expander input bits always read-only
// - Refresh trigger starts expander refresh transaction
// - Refresh trigger always reads as zero
// - Test mode control at bit twenty-five
// - Four-bit select; codes 0,1,2,4 valid
// - Expander done flag set, write-one clears
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module sea_access
    import sea_pkg::*;
(
    input  wire logic        clk_i,           // Core clock, 100 MHz
    input  wire logic        rst_i,           // Synchronous reset, high
    input  wire logic        wb_cyc_i,        // Wishbone cycle
    input  wire logic        wb_stb_i,        // Wishbone strobe
    input  wire logic        wb_we_i,         // Wishbone write
    input  wire logic [11:0] wb_adr_i,        // Byte address
    input  wire logic [3:0]  wb_sel_i,        // Byte lanes
    input  wire logic [31:0] wb_dat_i,        // Write data
    output logic             wb_ack_o,        // Acknowledge
    output logic      [31:0] wb_dat_o,        // Read data
    output logic             irq_o,           // Level interrupt
    output logic             smb_req_o,       // Job request, held until done
    output sea_pkg::sea_kind_t smb_kind_o,    // Job kind
    output logic      [15:0] smb_addr_o,      // EEPROM byte location
    output logic      [7:0]  smb_wdata_o,     // EEPROM write byte
    output logic      [3:0]  smb_ioe_sel_o,   // Target expander
    output logic      [15:0] smb_ioe_out_o,   // Output values sent to expander
    input  wire logic        smb_done_i,      // Job finished, one-cycle pulse
    input  wire logic [7:0]  smb_rdata_i,     // EEPROM byte, valid with done
    input  wire logic [15:0] smb_ioe_pins_i,  // Expander input values, valid with done
    input  wire logic [15:0] core_ioe_out_i,  // Outputs produced by internal logic
    input  wire logic [15:0] ioe_input_mask_i // Ones mark expander inputs
);
    import sea_pkg::*;

    // Bus handshake
    logic wr_stb;                             // Write commit
    logic rd_stb;                             // Read capture

    sea_wb_port u_wb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .ack_o (wb_ack_o),
        .wr_o  (wr_stb),
        .rd_o  (rd_stb)
    );

    // Address decode, word aligned
    logic hit_ee;
    logic hit_ioe;
    logic hit_ist;
    logic hit_imask;
    assign hit_ee    = (wb_adr_i[11:2] == SEA_EE_OFS[11:2]);
    assign hit_ioe   = (wb_adr_i[11:2] == SEA_IOE_OFS[11:2]);
    assign hit_ist   = (wb_adr_i[11:2] == SEA_IRQ_ST_OFS[11:2]);
    assign hit_imask = (wb_adr_i[11:2] == SEA_IRQ_MASK_OFS[11:2]);

    // Per-register write strobes by byte lane
    logic ee_wr_lo;                            // Location bytes
    logic ee_launch;                           // Data byte written
    logic ee_wr_hi;                            // Op and done byte
    logic ioe_wr_data;                         // Expander data bytes
    logic ioe_wr_hi;                           // Refresh, mode, select, done
    assign ee_wr_lo    = wr_stb & hit_ee & (wb_sel_i[0] | wb_sel_i[1]);
    assign ee_launch   = wr_stb & hit_ee & wb_sel_i[2];
    assign ee_wr_hi    = wr_stb & hit_ee & wb_sel_i[3];
    assign ioe_wr_data = wr_stb & hit_ioe & (wb_sel_i[0] | wb_sel_i[1]);
    assign ioe_wr_hi   = wr_stb & hit_ioe & wb_sel_i[3];

    // EEPROM side state
    logic [15:0] ee_addr_q;                    // Byte location
    logic [7:0]  ee_data_q;                    // Data byte
    logic        ee_op_q;                      // Operation select
    logic        ee_pend_q;                    // Launched, not yet on the bus
    logic        ee_done;                      // Sticky done flag
    logic        ee_busy;                      // Pending or on the bus

    // Expander side state
    logic        tm_q;                         // Test mode
    logic [3:0]  sel_q;                        // Selected expander code
    logic [15:0] tm_data_q;                    // Test mode output values
    logic [15:0] pins_q [SEA_NUM_IOE];         // Last known pin states per expander
    logic        ioe_pend_q;                   // Expander job waiting
    sea_kind_t   ioe_kind_q;                   // Waiting job kind
    logic [3:0]  ioe_tgt_q;                    // Waiting job target
    logic        ioe_done;                     // Sticky done flag

    // Job sequencer
    sea_state_t  state_q;

    // Valid select codes map onto storage slots
    function automatic logic [1:0] slot_of(input logic [3:0] code);
        case (code)
            SEA_IOE1: slot_of = 2'd1;
            SEA_IOE2: slot_of = 2'd2;
            SEA_IOE4: slot_of = 2'd3;
            default:  slot_of = 2'd0;
        endcase
    endfunction : slot_of

    logic sel_valid;                           // Reserved codes start nothing
    assign sel_valid = (sel_q == SEA_IOE0) | (sel_q == SEA_IOE1) | (sel_q == SEA_IOE2) | (sel_q == SEA_IOE4);

    logic refresh_req;                         // Trigger written with one
    logic update_req;                          // Test mode data written
    assign refresh_req = ioe_wr_hi & wb_dat_i[SEA_IOE_REFRESH_BIT] & sel_valid;
    assign update_req  = ioe_wr_data & tm_q & sel_valid;

    logic ee_finish;                           // EEPROM job ends
    logic ioe_finish;                          // Expander job ends
    assign ee_finish  = (state_q == SEA_ST_EE) & smb_done_i;
    assign ioe_finish = (state_q == SEA_ST_IOE) & smb_done_i;

    // Busy covers a launch still waiting behind an expander job
    assign ee_busy = ee_pend_q | (state_q == SEA_ST_EE);

    // EEPROM location and operation select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ee_addr_q <= SEA_RST_ADDR;
            ee_op_q   <= SEA_OP_WRITE;
        end else begin
            if (wr_stb & hit_ee & wb_sel_i[0]) begin
                ee_addr_q[7:0] <= wb_dat_i[7:0];
            end
            if (wr_stb & hit_ee & wb_sel_i[1]) begin
                ee_addr_q[15:8] <= wb_dat_i[15:8];
            end
            if (ee_wr_hi) begin
                ee_op_q <= wb_dat_i[SEA_EE_OP_BIT];
            end
        end
    end

    // EEPROM data byte: written value, or read result at finish
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ee_data_q <= SEA_RST_DATA;
        end else if (ee_finish & (smb_kind_o == SEA_KIND_EE_RD)) begin
            ee_data_q <= smb_rdata_i;
        end else if (ee_launch & ~ee_busy) begin
            ee_data_q <= wb_dat_i[23:16];
        end
    end

    // Launch while busy is dropped; software must poll busy first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ee_pend_q <= 1'b0;
        end else if (ee_launch & ~ee_busy) begin
            ee_pend_q <= 1'b1;
        end else if (state_q == SEA_ST_IDLE) begin
            ee_pend_q <= 1'b0;
        end
    end

    sea_sticky_bit u_ee_done (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (ee_finish),
        .clr_i (ee_wr_hi & wb_dat_i[SEA_EE_DONE_BIT]),
        .q_o   (ee_done)
    );

    // Expander mode, select and test data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tm_q      <= 1'b0;
            sel_q     <= SEA_RST_SEL;
            tm_data_q <= SEA_RST_PINS;
        end else begin
            if (ioe_wr_hi) begin
                tm_q  <= wb_dat_i[SEA_IOE_TM_BIT];
                sel_q <= wb_dat_i[SEA_IOE_SEL_LSB +: 4];
            end
            if (ioe_wr_data & tm_q) begin
                // Input bits keep their old value
                tm_data_q <= (wb_dat_i[15:0] & ~ioe_input_mask_i) | (tm_data_q & ioe_input_mask_i);
            end
        end
    end

    // One waiting expander job; a newer request replaces an older one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ioe_pend_q <= 1'b0;
            ioe_kind_q <= SEA_KIND_IOE_REF;
            ioe_tgt_q  <= SEA_RST_SEL;
        end else if (update_req | refresh_req) begin
            ioe_pend_q <= 1'b1;
            ioe_kind_q <= update_req ? SEA_KIND_IOE_UPD : SEA_KIND_IOE_REF;
            ioe_tgt_q  <= sel_q;
        end else if ((state_q == SEA_ST_IDLE) & ~ee_pend_q) begin
            ioe_pend_q <= 1'b0;
        end
    end

    // Pin state store: inputs from the bus on refresh, kept on update; outputs as supplied
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < SEA_NUM_IOE; i++) begin
                pins_q[i] <= SEA_RST_PINS;
            end
        end else if (ioe_finish) begin
            pins_q[slot_of(smb_ioe_sel_o)] <= (smb_ioe_out_o & ~ioe_input_mask_i)
                                            | ((smb_kind_o == SEA_KIND_IOE_REF ? smb_ioe_pins_i
                                               : pins_q[slot_of(smb_ioe_sel_o)]) & ioe_input_mask_i);
        end
    end

    sea_sticky_bit u_ioe_done (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (ioe_finish & (smb_ioe_sel_o == sel_q)),
        .clr_i (ioe_wr_hi & wb_dat_i[SEA_IOE_DONE_BIT]),
        .q_o   (ioe_done)
    );

    // Sequencer: EEPROM first, then expander, one job on the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q       <= SEA_ST_IDLE;
            smb_req_o     <= 1'b0;
            smb_kind_o    <= SEA_KIND_EE_WR;
            smb_addr_o    <= SEA_RST_ADDR;
            smb_wdata_o   <= SEA_RST_DATA;
            smb_ioe_sel_o <= SEA_RST_SEL;
            smb_ioe_out_o <= SEA_RST_PINS;
        end else begin
            case (state_q)
                SEA_ST_IDLE: begin
                    if (ee_pend_q) begin
                        state_q     <= SEA_ST_EE;
                        smb_req_o   <= 1'b1;
                        smb_kind_o  <= (ee_op_q == SEA_OP_READ) ? SEA_KIND_EE_RD : SEA_KIND_EE_WR;
                        smb_addr_o  <= ee_addr_q;
                        smb_wdata_o <= ee_data_q;
                    end else if (ioe_pend_q) begin
                        state_q       <= SEA_ST_IOE;
                        smb_req_o     <= 1'b1;
                        smb_kind_o    <= ioe_kind_q;
                        smb_ioe_sel_o <= ioe_tgt_q;
                        // Test mode overrides core outputs
                        smb_ioe_out_o <= tm_q ? tm_data_q : core_ioe_out_i;
                    end
                end
                SEA_ST_EE, SEA_ST_IOE: begin
                    // Request holds until the engine reports done
                    if (smb_done_i) begin
                        state_q   <= SEA_ST_IDLE;
                        smb_req_o <= 1'b0;
                    end
                end
                default: begin
                    state_q   <= SEA_ST_IDLE;
                    smb_req_o <= 1'b0;
                end
            endcase
        end
    end

    // Interrupt status and mask
    logic [SEA_IRQ_W-1:0] irq_st;
    logic [SEA_IRQ_W-1:0] irq_mask_q;
    logic [SEA_IRQ_W-1:0] irq_set;
    assign irq_set = {ioe_finish, ee_finish};

    for (genvar g = 0; g < SEA_IRQ_W; g++) begin : g_irq
        sea_sticky_bit u_st (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .set_i (irq_set[g]),
            .clr_i (wr_stb & hit_ist & wb_sel_i[0] & wb_dat_i[g]),
            .q_o   (irq_st[g])
        );
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= '0;
            irq_o      <= 1'b0;
        end else begin
            if (wr_stb & hit_imask & wb_sel_i[0]) begin
                irq_mask_q <= wb_dat_i[SEA_IRQ_W-1:0];
            end
            irq_o <= |(irq_st & irq_mask_q);
        end
    end

    // Read mux, registered as ack rises; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd_stb) begin
            wb_dat_o <= '0;
            if (hit_ee) begin
                wb_dat_o[15:0]            <= ee_addr_q;
                wb_dat_o[23:16]           <= ee_data_q;
                wb_dat_o[SEA_EE_BUSY_BIT] <= ee_busy;
                wb_dat_o[SEA_EE_DONE_BIT] <= ee_done;
                wb_dat_o[SEA_EE_OP_BIT]   <= ee_op_q;
            end else if (hit_ioe) begin
                wb_dat_o[15:0]                 <= pins_q[slot_of(sel_q)];
                wb_dat_o[SEA_IOE_TM_BIT]       <= tm_q;
                wb_dat_o[SEA_IOE_SEL_LSB +: 4] <= sel_q;
                wb_dat_o[SEA_IOE_DONE_BIT]     <= ioe_done;  // Refresh bit stays zero
            end else if (hit_ist) begin
                wb_dat_o[SEA_IRQ_W-1:0] <= irq_st;
            end else if (hit_imask) begin
                wb_dat_o[SEA_IRQ_W-1:0] <= irq_mask_q;
            end
        end
    end

    // Checks
    logic rd_ioe_q;                            // Last captured read was expander register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ioe_q <= 1'b0;
        end else if (rd_stb) begin
            rd_ioe_q <= hit_ioe;
        end
    end

    property p_launch_busy;
        @(posedge clk_i) disable iff (rst_i) (ee_launch & ~ee_busy) |=> ee_busy;
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("launch did not raise busy");

    property p_done_after_finish;
        @(posedge clk_i) disable iff (rst_i) ee_finish |=> (ee_done & ~ee_busy)[*1] ##0 (state_q == SEA_ST_IDLE);
    endproperty
    a_done_after_finish: assert property (p_done_after_finish) else $error("done or busy wrong after finish");

    property p_done_clear;
        @(posedge clk_i) disable iff (rst_i) (ee_wr_hi & wb_dat_i[SEA_EE_DONE_BIT] & ~ee_finish) |=> ~ee_done;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

    property p_read_result;
        @(posedge clk_i) disable iff (rst_i)
            (ee_finish & (smb_kind_o == SEA_KIND_EE_RD)) |=> (ee_data_q == $past(smb_rdata_i));
    endproperty
    a_read_result: assert property (p_read_result) else $error("read byte not stored");

    property p_write_byte;
        @(posedge clk_i) disable iff (rst_i)
            ((state_q == SEA_ST_EE) & (smb_kind_o == SEA_KIND_EE_WR)) |-> (smb_wdata_o == ee_data_q);
    endproperty
    a_write_byte: assert property (p_write_byte) else $error("write byte differs from data field");

    property p_tm_ignore;
        @(posedge clk_i) disable iff (rst_i)
            (ioe_wr_data & ~tm_q & ~refresh_req & ~ioe_pend_q) |=> $stable(tm_data_q) && !ioe_pend_q[*1];
    endproperty
    a_tm_ignore: assert property (p_tm_ignore) else $error("data write acted outside test mode");

    property p_refresh_zero;
        @(posedge clk_i) disable iff (rst_i) (wb_ack_o & rd_ioe_q) |-> ~wb_dat_o[SEA_IOE_REFRESH_BIT];
    endproperty
    a_refresh_zero: assert property (p_refresh_zero) else $error("refresh bit read as one");

    property p_one_job;
        @(posedge clk_i) disable iff (rst_i)
            (smb_req_o & ~smb_done_i) |=> smb_req_o && $stable(smb_kind_o) && $stable(smb_ioe_sel_o);
    endproperty
    a_one_job: assert property (p_one_job) else $error("job changed before done");

    property p_tm_outputs;
        @(posedge clk_i) disable iff (rst_i)
            ((state_q == SEA_ST_IDLE) & ~ee_pend_q & ioe_pend_q & tm_q) |=> (smb_ioe_out_o == $past(tm_data_q));
    endproperty
    a_tm_outputs: assert property (p_tm_outputs) else $error("test data not sent");

    c_ee_read: cover property (@(posedge clk_i) disable iff (rst_i) ee_finish && smb_kind_o == SEA_KIND_EE_RD);
    c_refresh: cover property (@(posedge clk_i) disable iff (rst_i) ioe_finish && smb_kind_o == SEA_KIND_IOE_REF);
    c_ee_waits: cover property (@(posedge clk_i) disable iff (rst_i) ee_pend_q && state_q == SEA_ST_IOE);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule : sea_access

// [tb/sea_smb_model.sv]
`timescale 1ns/1ns
// Behavioural SMBus engine with the EEPROM and expander behind it
module sea_smb_model
    import sea_pkg::*;
#(
    parameter logic [15:0] PINS = 16'hc35a  // Pin states the expander reports
) (
    input  wire logic        clk_i,    // Core clock
    input  wire logic        rst_i,    // Synchronous reset
    input  wire logic        req_i,    // Job request
    input  wire logic [1:0]  kind_i,   // Job kind
    input  wire logic [15:0] addr_i,   // EEPROM location
    input  wire logic [7:0]  wdata_i,  // EEPROM write byte
    output logic             done_o,   // Finish pulse
    output logic      [7:0]  rdata_o,  // Valid with done only
    output logic      [15:0] pins_o    // Valid with done only
);
    logic [7:0] mem_q [16];  // Low location bits only
    logic [4:0] cnt_q;       // Cycles into the job
    // Slow enough that software sees busy; one pulse per job
    always_ff @(posedge clk_i) begin
        cnt_q  <= (rst_i || !req_i) ? 5'h00 : cnt_q + {4'h0, cnt_q != 5'h1f};
        done_o <= !rst_i && req_i && cnt_q == 5'h0c;
        if (req_i && cnt_q == 5'h0c && kind_i == SEA_KIND_EE_WR) begin
            mem_q[addr_i[3:0]] <= wdata_i;
        end
    end
    // Stale values are inverted so they never pass for a result
    assign rdata_o = done_o ? mem_q[addr_i[3:0]] : ~mem_q[addr_i[3:0]];
    assign pins_o  = done_o ? PINS : ~PINS;
endmodule : sea_smb_model

// [tb/tb_top.sv]
`timescale 1ns/1ns
// Register-side bench for the EEPROM and expander access block
module tb_top;
    import sea_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, smb_req_o, smb_done_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i, smb_ioe_sel_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    sea_kind_t   smb_kind_o;
    logic [15:0] smb_addr_o, smb_ioe_out_o, smb_ioe_pins_i;
    logic [15:0] core_ioe_out_i = 16'h1234, ioe_input_mask_i = 16'h00ff;  // Low byte inputs
    logic [7:0]  smb_wdata_o, smb_rdata_i;
    int          bad_count = 0, compares = 0, cycles = 0;
    sea_access sea_access_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_ack_o, .wb_dat_o, .irq_o, .smb_req_o, .smb_kind_o, .smb_addr_o, .smb_wdata_o,
        .smb_ioe_sel_o, .smb_ioe_out_o, .smb_done_i, .smb_rdata_i, .smb_ioe_pins_i, .core_ioe_out_i,
        .ioe_input_mask_i);
    sea_smb_model sea_smb_model_i (.clk_i, .rst_i, .req_i(smb_req_o), .kind_i(smb_kind_o),
        .addr_i(smb_addr_o), .wdata_i(smb_wdata_o), .done_o(smb_done_i), .rdata_o(smb_rdata_i),
        .pins_o(smb_ioe_pins_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Hang guard; the run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One classic cycle, held until ack is sampled high; only the hang guard ends a wait
    task automatic wb(input logic we, input logic [11:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, dat};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    // Bounded poll of a flag bit
    task automatic poll(input logic [11:0] adr, input int b);
        int n;
        n = 0;
        do wb(1'b0, adr, 4'hf, 32'h0); while (rd[b] !== 1'b1 && ++n < 40);
    endtask : poll
    task automatic t_reset();
        wb(1'b0, SEA_EE_OFS, 4'hf, 32'h0);
        check("ee reset", rd, 32'h0);
        wb(1'b0, SEA_IOE_OFS, 4'hf, 32'h0);
        check("ioe reset", rd, 32'h0);
        wb(1'b0, 12'h3f0, 4'hf, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask : t_reset
    // Write a byte, then read it back; busy, done, interrupt along the way
    task automatic t_eeprom();
        wb(1'b1, SEA_IRQ_MASK_OFS, 4'h1, 32'h1);
        wb(1'b1, SEA_EE_OFS, 4'hf, 32'h00a5_0009);
        wb(1'b0, SEA_EE_OFS, 4'hf, 32'h0);
        check("busy", rd[25:24], 2'b01);
        check("job", {smb_req_o, smb_kind_o, smb_wdata_o}, {1'b1, SEA_KIND_EE_WR, 8'ha5});
        poll(SEA_EE_OFS, SEA_EE_DONE_BIT);
        check("wr done", rd[25:24], 2'b10);
        repeat (2) @(posedge clk_i);
        check("irq set", irq_o, 1'b1);
        wb(1'b1, SEA_IRQ_ST_OFS, 4'h1, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq clear", irq_o, 1'b0);
        wb(1'b1, SEA_EE_OFS, 4'h8, 32'h0600_0000);
        wb(1'b1, SEA_EE_OFS, 4'h4, 32'h005a_0000);
        // Pending at the commit edge, on the bus one edge later
        repeat (2) @(posedge clk_i);
        check("rd job", {smb_kind_o, smb_addr_o}, {SEA_KIND_EE_RD, 16'h0009});
        poll(SEA_EE_OFS, SEA_EE_DONE_BIT);
        check("rd data", rd, 32'h06a5_0009);
    endtask : t_eeprom
    // Refresh, ignored write, test mode update, reserved select
    task automatic t_expander();
        wb(1'b1, SEA_IRQ_MASK_OFS, 4'h1, 32'h2);
        repeat (2) @(posedge clk_i);
        check("masked", irq_o, 1'b0);
        wb(1'b1, SEA_IOE_OFS, 4'h8, 32'h0100_0000);
        poll(SEA_IOE_OFS, SEA_IOE_DONE_BIT);
        check("refresh", rd, 32'h8000_125a);
        check("irq ioe", irq_o, 1'b1);
        wb(1'b1, SEA_IOE_OFS, 4'h3, 32'h0000_ffff);
        wb(1'b0, SEA_IOE_OFS, 4'hf, 32'h0);
        check("no tm", rd[15:0], 16'h125a);
        wb(1'b1, SEA_IOE_OFS, 4'h8, 32'h8200_0000);
        wb(1'b1, SEA_IOE_OFS, 4'h3, 32'h0000_abcd);
        poll(SEA_IOE_OFS, SEA_IOE_DONE_BIT);
        check("tm data", rd, 32'h8200_ab5a);
        // Refresh checks the select already held, so select the reserved code first
        wb(1'b1, SEA_IOE_OFS, 4'h8, 32'h8c00_0000);
        wb(1'b1, SEA_IOE_OFS, 4'h8, 32'h8d00_0000);
        repeat (4) @(posedge clk_i);
        check("reserved", {smb_req_o, smb_kind_o, smb_ioe_sel_o}, {1'b0, SEA_KIND_IOE_UPD, SEA_IOE0});
    endtask : t_expander
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 48'h0};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_eeprom();
        t_expander();
        end_of_test();
    end
endmodule : tb_top
